// ### verilog/fst_map.vh
// Constants for the floating-point status and trap unit
// What this block does
// RULE1 - Fifth return word: carry in bit 0, return address in bits 1-15
// RULE2 - Saved return address is the word after the faulting instruction
// RULE3 - Taking a fault clears trap enable before entering the handler
// RULE4 - Handler software sets trap enable again before resuming
// RULE5 - Status updates after every completed instruction, then fault check
// RULE6 - Compare sets zero and negative flags from the outcome
// RULE7 - Never-skip never skips; always-skip always skips
// RULE8 - Skip on zero flag one; skip-nonzero on zero flag zero
// RULE9 - Skip on negative zero; skip-negative on negative one
// RULE10 - Skip-positive only when zero and negative both zero
// RULE11 - Skip-not-positive when zero or negative is one
// RULE12 - Single-flag skips skip when the named error flag is zero
// RULE13 - Skip-no-error skips when status bits 1-4 are zero
// RULE14 - Paired skips skip only when both named flags are zero
// RULE15 - Clear-errors zeroes bits 0-4, keeps the rest
// RULE16 - Load-status copies two memory words into the status word
// RULE17 - Store-status writes the status word to two memory words
// RULE18 - Trap-disable clears trap enable; trap-enable sets it
// RULE19 - Bit layout: any,ovf,unf,dvz,mof,te,z,n; any = OR of 1-4
// RULE20 - With trap enable one, any error bit set causes a trap; code traps only on a done command with nonzero error inputs
// RULE21 - Trap before next instruction, push five words, jump via 45 octal; code stores only the fifth word (blk_reg[4])
// RULE22 - Fault records instruction address in 15-bit fault address field
// RULE23 - Taken skip advances past one extra word; else normal advance
`ifndef FST_MAP_VH
`define FST_MAP_VH
// ========================================
// Register offsets
`define FST_OFF_STAT0 8'h00
`define FST_OFF_STAT1 8'h04
`define FST_OFF_CMD 8'h08
`define FST_OFF_RESULT 8'h0c
`define FST_OFF_PC 8'h10
`define FST_OFF_TRAP 8'h14
`define FST_OFF_BLK 8'h18
// ========================================
// Status bit positions
`define FST_B_ANY 0
`define FST_B_OVF 1
`define FST_B_UNF 2
`define FST_B_DVZ 3
`define FST_B_MOF 4
`define FST_B_TE 5
`define FST_B_Z 6
`define FST_B_N 7
`define FST_B_RES 9
`define FST_IMPL_CODE 4'h5
`define FST_TRAP_VECTOR 16'h0025
// ========================================
// Command codes
`define FST_OP_NONE 5'h00
`define FST_OP_DONE 5'h01
`define FST_OP_CMP 5'h02
`define FST_OP_NS 5'h03
`define FST_OP_SA 5'h04
`define FST_OP_SEQ 5'h05
`define FST_OP_SNE 5'h06
`define FST_OP_SGE 5'h07
`define FST_OP_SLT 5'h08
`define FST_OP_SGT 5'h09
`define FST_OP_SLE 5'h0a
`define FST_OP_SND 5'h0b
`define FST_OP_SNER 5'h0c
`define FST_OP_SNM 5'h0d
`define FST_OP_SNO 5'h0e
`define FST_OP_SNU 5'h0f
`define FST_OP_SNOD 5'h10
`define FST_OP_SNUD 5'h11
`define FST_OP_SNUO 5'h12
`define FST_OP_CLE 5'h13
`define FST_OP_LST 5'h14
`define FST_OP_SST 5'h15
`define FST_OP_TD 5'h16
`define FST_OP_TE 5'h17
`endif

// ### verilog/fst_unit.v
// Floating-point status, skip and trap unit with AHB-Lite registers
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "fst_map.vh"
module fst_unit (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output reg trap_pulse,
	output reg skip_taken
);
	// ========================================
	// Bus address phase capture
	reg wr_reg;
	reg rd_reg;
	reg [7:0] addr_reg;
	wire take = hsel & hready & htrans[1];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else begin
			wr_reg <= take & hwrite;
			rd_reg <= take & ~hwrite;
			addr_reg <= haddr[7:0];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ========================================
	// State
	reg [7:0] flags_reg;
	reg res_reg;
	reg [14:0] fault_pc_reg;
	reg [15:0] pc_reg;
	reg carry_reg;
	reg [31:0] result_reg;
	reg [31:0] store_reg;
	reg [4:0] trap_cnt_reg;
	reg [15:0] blk_reg [0:4];

	wire [15:0] stat_w0 = {`FST_IMPL_CODE, 2'b00, res_reg, 1'b0,
		flags_reg[7:1], |flags_reg[4:1]}; // RULE19
	wire [15:0] stat_w1 = {1'b0, fault_pc_reg};

	// Skip evaluation
	function skip_eval;
		input [4:0] op;
		input [7:0] f;
		begin
			case (op)
				`FST_OP_NS: skip_eval = 1'b0; // RULE7
				`FST_OP_SA: skip_eval = 1'b1; // RULE7
				`FST_OP_SEQ: skip_eval = f[`FST_B_Z]; // RULE8
				`FST_OP_SNE: skip_eval = ~f[`FST_B_Z]; // RULE8
				`FST_OP_SGE: skip_eval = ~f[`FST_B_N]; // RULE9
				`FST_OP_SLT: skip_eval = f[`FST_B_N]; // RULE9
				`FST_OP_SGT: skip_eval = ~(f[`FST_B_Z] | f[`FST_B_N]); // RULE10
				`FST_OP_SLE: skip_eval = f[`FST_B_Z] | f[`FST_B_N]; // RULE11
				`FST_OP_SND: skip_eval = ~f[`FST_B_DVZ]; // RULE12
				`FST_OP_SNM: skip_eval = ~f[`FST_B_MOF]; // RULE12
				`FST_OP_SNO: skip_eval = ~f[`FST_B_OVF]; // RULE12
				`FST_OP_SNU: skip_eval = ~f[`FST_B_UNF]; // RULE12
				`FST_OP_SNER: skip_eval = ~|f[4:1]; // RULE13
				`FST_OP_SNOD: skip_eval = ~(f[1] | f[3]); // RULE14
				`FST_OP_SNUD: skip_eval = ~(f[2] | f[3]); // RULE14
				`FST_OP_SNUO: skip_eval = ~(f[2] | f[1]); // RULE14
				default: skip_eval = 1'b0;
			endcase
		end
	endfunction

	// ========================================
	// Command decode from a bus write
	wire cmd_wr = wr_reg & (addr_reg == `FST_OFF_CMD);
	wire [4:0] op = hwdata[4:0];
	wire [3:0] err_in = hwdata[11:8];
	wire z_in = hwdata[12];
	wire n_in = hwdata[13];
	wire carry_in = hwdata[14];
	wire [15:0] ipc_in = hwdata[31:16];
	wire cmd_busy = (trap_cnt_reg != 5'd0);

	reg [7:0] f_next;
	reg res_next;
	reg [14:0] fpc_next;
	reg trap_next;
	always @* begin
		f_next = flags_reg;
		res_next = res_reg;
		fpc_next = fault_pc_reg;
		if (cmd_wr & ~cmd_busy) begin
			case (op)
				`FST_OP_DONE: begin
					f_next[4:1] = flags_reg[4:1] | err_in; // RULE5
					f_next[`FST_B_Z] = z_in;
					f_next[`FST_B_N] = n_in;
				end
				`FST_OP_CMP: begin
					f_next[`FST_B_Z] = z_in; // RULE6
					f_next[`FST_B_N] = n_in; // RULE6
				end
				`FST_OP_CLE: f_next[4:0] = 5'h00; // RULE15
				`FST_OP_TD: f_next[`FST_B_TE] = 1'b0; // RULE18
				`FST_OP_TE: f_next[`FST_B_TE] = 1'b1; // RULE18
				`FST_OP_LST: begin
					f_next = store_reg[7:0]; // RULE16
					res_next = store_reg[`FST_B_RES];
					fpc_next = store_reg[30:16]; // RULE16
				end
				default: f_next = flags_reg;
			endcase
		end
		f_next[`FST_B_ANY] = |f_next[4:1]; // RULE19
		trap_next = 1'b0;
		if (cmd_wr & ~cmd_busy & (op == `FST_OP_DONE) &&
			flags_reg[`FST_B_TE] && (|err_in)) begin
			trap_next = 1'b1; // RULE20
			f_next[`FST_B_TE] = 1'b0; // RULE3
			fpc_next = ipc_in[14:0]; // RULE22
		end
	end

	// ========================================
	// Status, program counter, return block
	integer i;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_reg <= 8'h00;
			res_reg <= 1'b0;
			fault_pc_reg <= 15'h0000;
			pc_reg <= 16'h0000;
			carry_reg <= 1'b0;
			result_reg <= 32'h0;
			store_reg <= 32'h0;
			trap_cnt_reg <= 5'd0;
			trap_pulse <= 1'b0;
			skip_taken <= 1'b0;
			for (i = 0; i < 5; i = i + 1)
				blk_reg[i] <= 16'h0000;
		end else begin
			flags_reg <= f_next; // RULE5
			res_reg <= res_next;
			fault_pc_reg <= fpc_next;
			trap_pulse <= trap_next;
			skip_taken <= 1'b0;
			if (wr_reg & (addr_reg == `FST_OFF_STAT0))
				store_reg[15:0] <= hwdata[15:0];
			if (wr_reg & (addr_reg == `FST_OFF_STAT1))
				store_reg[31:16] <= hwdata[15:0];
			if (wr_reg & (addr_reg == `FST_OFF_BLK))
				for (i = 0; i < 4; i = i + 1)
					blk_reg[i] <= blk_reg[i];
			if (cmd_wr & ~cmd_busy) begin
				carry_reg <= carry_in;
				if (skip_eval(op, flags_reg)) begin
					pc_reg <= ipc_in + 16'd2; // RULE23
					skip_taken <= 1'b1;
				end else
					pc_reg <= ipc_in + 16'd1; // RULE23
				if (op == `FST_OP_SST)
					result_reg <= {stat_w1, stat_w0}; // RULE17
				else
					result_reg <= {27'h0, op};
			end
			if (trap_next) begin
				// RULE21
				trap_cnt_reg <= 5'd5;
				blk_reg[4] <= {ipc_in[14:0] + 15'd1, carry_in}; // RULE1 RULE2
			end else if (cmd_busy) begin
				trap_cnt_reg <= trap_cnt_reg - 5'd1;
				if (trap_cnt_reg == 5'd1)
					pc_reg <= `FST_TRAP_VECTOR; // RULE21
			end
		end
	end

	// ========================================
	// Read mux
	reg [31:0] rd_mux;
	always @* begin
		case (addr_reg)
			`FST_OFF_STAT0: rd_mux = {16'h0, stat_w0};
			`FST_OFF_STAT1: rd_mux = {16'h0, stat_w1};
			`FST_OFF_RESULT: rd_mux = result_reg;
			`FST_OFF_PC: rd_mux = {15'h0, carry_reg, pc_reg};
			`FST_OFF_TRAP: rd_mux = {27'h0, trap_cnt_reg};
			`FST_OFF_BLK: rd_mux = {16'h0, blk_reg[4]};
			default: rd_mux = 32'h0;
		endcase
	end
	assign hrdata = rd_reg ? rd_mux : 32'h0;
endmodule // fst_unit

// ### test/fst_properties.sv
// Checker of skip and trap pulses against accepted commands
`timescale 1ns/1ps
`include "fst_map.vh"
module fst_properties (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire trap_pulse,
	input wire skip_taken
);
	reg go_reg;
	wire [4:0] op;
	assign op = hwdata[4:0];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ========================================
	// Data phase of a command write
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
			go_reg <= 1'b0;
		else
			go_reg <= hsel & hready & htrans[1] & hwrite
				& (haddr[7:0] == `FST_OFF_CMD);
	AST_SA: assert property (go_reg && op == `FST_OP_SA |=> skip_taken)
		else $error("always-skip did not skip");
	AST_NS: assert property (go_reg && op == `FST_OP_NS |=> !skip_taken)
		else $error("never-skip skipped");
	AST_SKIP_SRC: assert property (skip_taken |-> $past(go_reg))
		else $error("skip without a command");
	AST_TRAP_SRC: assert property (trap_pulse |-> $past(go_reg)
		&& $past(op) == `FST_OP_DONE) else $error("trap without completion");
	AST_NO_ERR: assert property (go_reg && op == `FST_OP_DONE
		&& hwdata[11:8] == 4'h0 |=> !trap_pulse) else $error("trap no error");
	AST_ONCE: assert property (trap_pulse |=> !trap_pulse [*5])
		else $error("trap repeated");
	AST_CLE: assert property (go_reg && op == `FST_OP_CLE
		|=> !trap_pulse && !skip_taken) else $error("clear trapped");
	AST_TD: assert property (go_reg && op == `FST_OP_TD |=> !trap_pulse)
		else $error("disable trapped");
endmodule // fst_properties
bind fst_unit fst_properties u_fst_properties (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .trap_pulse, .skip_taken);

// ### test/fst_unit_tb.sv
// Bench of the status, skip and trap unit
`timescale 1ns/1ps
`include "fst_map.vh"
module fst_unit_tb;
	reg hclk, hresetn, hsel, hwrite, z, n;
	reg [31:0] haddr, hwdata, rd, rdq;
	reg [1:0] htrans;
	reg [3:0] e;
	wire [31:0] hrdata;
	wire hreadyout, hresp, trap_pulse, skip_taken;
	integer failures, checked, k, o;
	integer cyc = 0;
	fst_unit u_fst_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .trap_pulse(trap_pulse),
		.skip_taken(skip_taken));
	// ========================================
	// Clock, capture and timeout
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		rdq <= hrdata;
		cyc = cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			final_report;
		end
	end
	// ========================================
	// Tasks
	task final_report;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp, input [39:0] what);
		checked = checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0s exp %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		#1;
		rd = rdq;
	endtask
	function [31:0] cmd(input [4:0] op);
		cmd = {16'h0, 2'b0, n, z, e, 3'b0, op};
	endfunction
	function xs(input [4:0] op);
		case (op)
			`FST_OP_SA: xs = 1'b1;
			`FST_OP_SEQ: xs = z;
			`FST_OP_SNE: xs = !z;
			`FST_OP_SGE: xs = !n;
			`FST_OP_SLT: xs = n;
			`FST_OP_SGT: xs = !z && !n;
			`FST_OP_SLE: xs = z || n;
			`FST_OP_SND: xs = !e[2];
			`FST_OP_SNER: xs = e == 4'h0;
			`FST_OP_SNM: xs = !e[3];
			`FST_OP_SNO: xs = !e[0];
			`FST_OP_SNU: xs = !e[1];
			`FST_OP_SNOD: xs = !e[0] && !e[2];
			`FST_OP_SNUD: xs = !e[1] && !e[2];
			`FST_OP_SNUO: xs = !e[1] && !e[0];
			default: xs = 1'b0;
		endcase
	endfunction
	// ========================================
	// Sequence
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
		{failures, checked, e, z, n} = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `FST_OFF_STAT0, 0);
		chk(rd[7:0], 0, "reset");
		chk(rd[15:8], {`FST_IMPL_CODE, 4'h0}, "impl");
		chk({hreadyout, hresp}, 2'b10, "resp");
		for (k = 0; k < 64; k = k + 1) begin
			{n, z, e} = k;
			bus(1, `FST_OFF_CMD, cmd(`FST_OP_CLE));
			bus(1, `FST_OFF_CMD, cmd(`FST_OP_DONE));
			bus(0, `FST_OFF_STAT0, 0);
			chk(rd[7:0], {n, z, 1'b0, e, |e}, "stat0");
			for (o = 3; o < 19; o = o + 1) begin
				bus(1, `FST_OFF_CMD, cmd(o[4:0]));
				chk(skip_taken, xs(o[4:0]), "skip");
			end
		end
		{n, z, e} = 6'h10;
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_CMP));
		bus(0, `FST_OFF_STAT0, 0);
		chk(rd[7:6], 2'b01, "cmp");
		e = 4'h0;
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_CLE));
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_TE));
		bus(1, `FST_OFF_CMD, 32'h1234_4101);
		chk(trap_pulse, 1, "trap");
		repeat (6) @(posedge hclk);
		bus(0, `FST_OFF_STAT0, 0);
		chk(rd[5:0], 6'h03, "te");
		bus(0, `FST_OFF_STAT1, 0);
		chk(rd[15:0], 16'h1234, "fpc");
		bus(0, `FST_OFF_BLK, 0);
		chk(rd[15:0], 16'h246b, "blk");
		bus(0, `FST_OFF_PC, 0);
		chk(rd[15:0], `FST_TRAP_VECTOR, "pc");
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_TE));
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_CLE));
		bus(0, `FST_OFF_STAT0, 0);
		chk(rd[5:0], 6'h20, "cle");
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_TD));
		bus(0, `FST_OFF_STAT0, 0);
		chk(rd[5], 0, "td");
		bus(1, `FST_OFF_STAT0, 32'h47);
		bus(1, `FST_OFF_STAT1, 32'h0abc);
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_LST));
		bus(0, `FST_OFF_STAT0, 0);
		chk(rd[7:0], 8'h47, "ld");
		bus(1, `FST_OFF_CMD, cmd(`FST_OP_SST));
		bus(0, `FST_OFF_RESULT, 0);
		chk({rd[31:16], rd[7:0]}, 24'h0abc47, "st");
		bus(0, 8'h40, 0);
		chk(rd, 0, "unmap");
		final_report;
	end
endmodule // fst_unit_tb
